//--- hw/ddtc_regs.svh
// register map, field positions, reset values and timing figures of the timing core
`ifndef DDTC_REGS_SVH
`define DDTC_REGS_SVH

// ==========================================================
// timing figures
`define DDTC_CLK_MHZ        100
`define DDTC_CLK_NS         (1000 / `DDTC_CLK_MHZ)
`define DDTC_CW             39
`define DDTC_FW             12
`define DDTC_FINE_STEP_PS   5
`define DDTC_FINE_MAX_PS    9995
`define DDTC_FINE_MAX       12'(`DDTC_FINE_MAX_PS / `DDTC_FINE_STEP_PS)
`define DDTC_MAX_DLY_S      2000
`define DDTC_NCH            10
`define DDTC_NOUT           14

// ==========================================================
// register offsets
`define DDTC_A_CTRL         8'h00
`define DDTC_A_RATE         8'h04
`define DDTC_A_POL          8'h08
`define DDTC_A_GATE         8'h0C
`define DDTC_A_SPIEN        8'h10
`define DDTC_A_STAT         8'h14
`define DDTC_A_MASK         8'h18
`define DDTC_A_STATE        8'h1C
`define DDTC_A_DLO          2'h1
`define DDTC_A_DHI          2'h2
`define DDTC_A_FINE         2'h3

// ==========================================================
// fields and reset values
`define DDTC_C_EXTREF       2
`define DDTC_C_ARM          3
`define DDTC_C_QUIET        4
`define DDTC_S_TRIG         0
`define DDTC_S_DONE         1
`define DDTC_S_MISS         2
`define DDTC_S_PWR          3
`define DDTC_RATE_RST       32'h0098_967F

`endif

//--- hw/ddtc_pkg.sv
// shared types of the timing core
`include "ddtc_regs.svh"
package ddtc_pkg;
  typedef enum logic [0:0] {S_IDLE, S_RUN} ddtc_state_t;
  typedef enum logic [1:0] {SRC_EXT, SRC_LINE, SRC_SYNTH} ddtc_src_t;
  typedef struct packed {
    logic [`DDTC_CW-1:0] cnt;
    logic                busy;
  } ddtc_chan_t;
endpackage

//--- hw/ddtc_chan_if.sv
// link between the core and one coarse delay counter
`timescale 1ns/1ps
`include "ddtc_regs.svh"
interface ddtc_chan_if;
  logic                start;
  logic [`DDTC_CW-1:0] dly;
  logic                done;
  logic                busy;
  modport core (output start, output dly, input done, input busy);
  modport chan (input start, input dly, output done, output busy);
endinterface

//--- hw/ddtc_chan.sv
// one 39-bit coarse delay counter
`timescale 1ns/1ps
`include "ddtc_regs.svh"
module ddtc_chan
  import ddtc_pkg::*;
(
  input wire logic clk,   // master clock
  input wire logic reset, // sync, high
  ddtc_chan_if.chan ch    // start, delay, terminal event
);
  ddtc_chan_t r;
  ddtc_chan_t n;

  // ==========================================================
  // counter
  always_comb begin
    n = r;
    if (ch.start) begin
      n.cnt  = '0;
      n.busy = 1'b1;
    end else if (ch.done) begin
      n.busy = 1'b0;
    end else if (r.busy) begin
      n.cnt = r.cnt + 39'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // a restart wins over a pending terminal count
  assign ch.done = r.busy && (r.cnt == ch.dly) && !ch.start;
  assign ch.busy = r.busy;

  // ==========================================================
  // checks
  count_hit_a: assert property (@(posedge clk) disable iff (reset)
    (ch.start && ch.dly == 39'h3) ##1 (!ch.start)[*4] |-> ch.done)
    else $error("terminal event not at programmed count");
  done_ends_a: assert property (@(posedge clk) disable iff (reset)
    (ch.done && !ch.start) |=> !r.busy && !ch.done)
    else $error("channel still busy after terminal event");
endmodule // ddtc_chan

//--- hw/ddtc_core.sv
// timing core top: registers, trigger path, channels, output shaping, spi gating
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ddtc_regs.svh"

module ddtc_core
  import ddtc_pkg::*;
(
  input  wire logic        clk,                      // 100 MHz master clock
  input  wire logic        reset,                    // sync, high
  input  wire logic [7:0]  addr,                     // register address
  input  wire logic [31:0] wdata,                    // write data
  input  wire logic        wr,                       // write strobe
  input  wire logic        rd,                       // read strobe
  output logic      [31:0] rdata,                    // read data, cycle after rd
  output logic             irq,                      // level interrupt
  input  wire logic        ext_trig_pin,             // external trigger
  input  wire logic        line_trig_pin,            // power line trigger
  input  wire logic        power_ok_pin,             // supply monitor, high = ok
  output logic             power_fail,               // to controller, high = lost
  output logic             master_clock_source_ext,  // lock to external ref
  input  wire logic        mcu_sck,                  // controller spi clock
  input  wire logic        mcu_mosi,                 // controller spi data out
  input  wire logic        mcu_cs_n,                 // controller spi select
  output logic             mcu_miso,                 // spi data to controller
  output logic             board_sck,                // buffered spi clock
  output logic             board_mosi,               // buffered spi data
  output logic      [1:0]  board_cs_n,               // per-board select
  input  wire logic [1:0]  board_miso,               // per-board data in
  output logic      [119:0] fine_delay_vernier,      // 10 x 12-bit fine settings
  output logic             reference_output,         // reference width
  output logic             pair_one_width_output,    // first pair width
  output logic             pair_two_width_output,    // second pair width
  output logic             pair_three_width_output,  // third pair width
  output logic             pair_four_width_output,   // fourth pair width
  output logic      [8:0]  edge_out                  // reference and eight edges
);

  typedef struct packed {
    ddtc_state_t                    st;
    logic                           start;
    logic [2:0]                     ext_s;
    logic [2:0]                     line_s;
    logic [2:0]                     pwr_s;
    logic [1:0]                     sck_s;
    logic [1:0]                     mosi_s;
    logic [1:0]                     csn_s;
    logic [1:0][1:0]                miso_s;
    logic [4:0]                     ctrl;
    logic [31:0]                    rate;
    logic [31:0]                    rcnt;
    logic [`DDTC_NOUT-1:0]          pol;
    logic [`DDTC_NOUT-1:0]          gate;
    logic [1:0]                     spien;
    logic [3:0]                     stat;
    logic [3:0]                     mask;
    logic [`DDTC_NCH-1:0][38:0]     dly;
    logic [`DDTC_NCH-1:0][11:0]     fine;
    logic [4:0]                     w;
    logic [8:0]                     e;
    logic [`DDTC_NOUT-1:0]          outs;
    logic [31:0]                    rdata;
    logic                           irq;
    logic                           sck;
    logic                           mosi;
    logic [1:0]                     cs_n;
    logic                           miso;
    logic                           pwr_fail;
  } ddtc_core_t;

  ddtc_core_t          r;
  ddtc_core_t          n;
  logic [`DDTC_NCH-1:0] done;
  logic [`DDTC_NCH-1:0] busy;
  logic                trig;
  logic                synth;
  logic                idle_w;
  logic [3:0]          ev;
  logic [3:0]          idx;
  logic                in_tab;

  // ==========================================================
  // coarse channels
  ddtc_chan_if cif[`DDTC_NCH] ();
  for (genvar g = 0; g < `DDTC_NCH; g++) begin : g_ch
    assign cif[g].start = r.start;
    assign cif[g].dly   = r.dly[g];
    assign done[g]      = cif[g].done;
    assign busy[g]      = cif[g].busy;
    ddtc_chan u_ch (
      .clk   (clk),
      .reset (reset),
      .ch    (cif[g])
    );
  end

  // ==========================================================
  // next state
  always_comb begin
    n      = r;
    idx    = addr[5:2];
    in_tab = (idx < 4'(`DDTC_NCH));

    // trigger_synchroniser: two flops, third keeps history for the edge
    n.ext_s  = {r.ext_s[1:0], ext_trig_pin};
    n.line_s = {r.line_s[1:0], line_trig_pin};
    n.pwr_s  = {r.pwr_s[1:0], power_ok_pin};
    n.sck_s  = {r.sck_s[0], mcu_sck};
    n.mosi_s = {r.mosi_s[0], mcu_mosi};
    n.csn_s  = {r.csn_s[0], mcu_cs_n};
    for (int b = 0; b < 2; b++) begin
      n.miso_s[b] = {r.miso_s[b][0], board_miso[b]};
    end

    // rate synthesizer: one tick every rate+1 cycles
    synth  = (r.rcnt >= r.rate);
    n.rcnt = synth ? 32'h0000_0000 : r.rcnt + 32'h0000_0001;

    // trigger_source_selector
    case (r.ctrl[1:0])
      SRC_EXT:   trig = r.ext_s[1] & ~r.ext_s[2];
      SRC_LINE:  trig = r.line_s[1] & ~r.line_s[2];
      SRC_SYNTH: trig = synth;
      default:   trig = 1'b0;
    endcase

    // a trigger is only taken between timing cycles
    idle_w  = (r.st == S_IDLE) && !r.start;
    n.start = trig && idle_w && r.ctrl[`DDTC_C_ARM];

    case (r.st)
      S_IDLE:  if (r.start) n.st = S_RUN;
      S_RUN:   if (busy == '0) n.st = S_IDLE;
      default: n.st = S_IDLE;
    endcase

    // ==========================================================
    // output_shaping_logic
    if (r.start) begin
      n.e = '0;
      n.w = '0;
    end
    for (int i = 0; i < 9; i++) begin
      if (done[i]) n.e[i] = 1'b1;
    end
    if (done[0]) n.w[0] = 1'b1;
    if (done[9]) n.w[0] = 1'b0;
    for (int p = 1; p < 5; p++) begin
      if (done[2*p-1]) n.w[p] = 1'b1;
      if (done[2*p])   n.w[p] = 1'b0;
    end
    // gated outputs rest at their inactive level
    n.outs = r.pol ^ ({r.e, r.w} & r.gate);

    // ==========================================================
    // spi buffering; quiet mode keeps boards silent during a cycle
    n.sck  = r.sck_s[1];
    n.mosi = r.mosi_s[1];
    for (int b = 0; b < 2; b++) begin
      n.cs_n[b] = r.csn_s[1] | ~r.spien[b] |
                  (r.ctrl[`DDTC_C_QUIET] & (r.st == S_RUN));
    end
    n.miso = !r.cs_n[0] ? r.miso_s[0][1] : r.miso_s[1][1];

    // ==========================================================
    // power monitor
    n.pwr_fail = ~r.pwr_s[1];

    // ==========================================================
    // register writes
    if (wr) begin
      case (addr)
        `DDTC_A_CTRL:  n.ctrl  = wdata[4:0];
        `DDTC_A_RATE:  n.rate  = wdata;
        `DDTC_A_POL:   n.pol   = wdata[`DDTC_NOUT-1:0];
        `DDTC_A_GATE:  n.gate  = wdata[`DDTC_NOUT-1:0];
        `DDTC_A_SPIEN: n.spien = wdata[1:0];
        `DDTC_A_MASK:  n.mask  = wdata[3:0];
        default: begin
          if (in_tab && addr[1:0] == 2'h0) begin
            case (addr[7:6])
              `DDTC_A_DLO: n.dly[idx][31:0]  = wdata;
              `DDTC_A_DHI: n.dly[idx][38:32] = wdata[6:0];
              `DDTC_A_FINE: begin
                // anything past 9.995 ns saturates
                n.fine[idx] = (wdata[11:0] > `DDTC_FINE_MAX) ?
                              `DDTC_FINE_MAX : wdata[11:0];
              end
              default: n.fine[idx] = r.fine[idx];
            endcase
          end
        end
      endcase
    end

    // ==========================================================
    // register reads, data stands one cycle
    n.rdata = '0;
    if (rd) begin
      case (addr)
        `DDTC_A_CTRL:  n.rdata = {27'h000_0000, r.ctrl};
        `DDTC_A_RATE:  n.rdata = r.rate;
        `DDTC_A_POL:   n.rdata = {18'h0_0000, r.pol};
        `DDTC_A_GATE:  n.rdata = {18'h0_0000, r.gate};
        `DDTC_A_SPIEN: n.rdata = {30'h0000_0000, r.spien};
        `DDTC_A_STAT:  n.rdata = {28'h000_0000, r.stat};
        `DDTC_A_MASK:  n.rdata = {28'h000_0000, r.mask};
        `DDTC_A_STATE: n.rdata = {20'h0_0000, r.pwr_s[1], r.st, busy};
        default: begin
          if (in_tab && addr[1:0] == 2'h0) begin
            case (addr[7:6])
              `DDTC_A_DLO:  n.rdata = r.dly[idx][31:0];
              `DDTC_A_DHI:  n.rdata = {25'h000_0000, r.dly[idx][38:32]};
              `DDTC_A_FINE: n.rdata = {20'h0_0000, r.fine[idx]};
              default:      n.rdata = '0;
            endcase
          end
        end
      endcase
    end

    // ==========================================================
    // sticky status: a new event wins over the read that clears
    ev[`DDTC_S_TRIG] = r.start;
    ev[`DDTC_S_DONE] = (r.st == S_RUN) && (busy == '0);
    ev[`DDTC_S_MISS] = trig && !idle_w;
    ev[`DDTC_S_PWR]  = r.pwr_s[2] & ~r.pwr_s[1];
    n.stat = ((rd && addr == `DDTC_A_STAT) ? 4'h0 : r.stat) | ev;
    n.irq  = |(n.stat & r.mask);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r       <= '0;
      r.rate  <= `DDTC_RATE_RST;
      r.pwr_s <= 3'h7;
      r.csn_s <= 2'h3;
      r.cs_n  <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs
  assign rdata                   = r.rdata;
  assign irq                     = r.irq;
  assign power_fail              = r.pwr_fail;
  assign master_clock_source_ext = r.ctrl[`DDTC_C_EXTREF];
  assign mcu_miso                = r.miso;
  assign board_sck               = r.sck;
  assign board_mosi              = r.mosi;
  assign board_cs_n              = r.cs_n;
  assign fine_delay_vernier      = r.fine;
  assign reference_output        = r.outs[0];
  assign pair_one_width_output   = r.outs[1];
  assign pair_two_width_output   = r.outs[2];
  assign pair_three_width_output = r.outs[3];
  assign pair_four_width_output  = r.outs[4];
  assign edge_out                = r.outs[13:5];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sync_latency_a: assert property ($rose(ext_trig_pin) |-> ##2 r.ext_s[1])
    else $error("trigger not through two flops");
  ext_start_a: assert property (
    (r.ctrl[1:0] == SRC_EXT && r.ctrl[3] && idle_w && $rose(r.ext_s[1])) |=> r.start)
    else $error("external trigger did not start cycle");
  line_start_a: assert property (
    (r.ctrl[1:0] == SRC_LINE && r.ctrl[3] && idle_w && $rose(r.line_s[1])) |=> r.start)
    else $error("line trigger did not start cycle");
  fine_clamp_a: assert property (
    (wr && addr == 8'hC0 && wdata[11:0] > `DDTC_FINE_MAX) |=> r.fine[0] == `DDTC_FINE_MAX)
    else $error("fine setting not clamped");
  pair_open_a: assert property ((done[1] && !done[2] && !r.start) |=> r.w[1])
    else $error("pair width not opened");
  pair_close_a: assert property (done[2] |=> ##1 pair_one_width_output == $past(r.pol[1]))
    else $error("pair width not closed");
  gate_off_a: assert property (!r.gate[5] |=> edge_out[0] == $past(r.pol[5]))
    else $error("gated output not at rest level");
  spi_quiet_a: assert property (!r.spien[0] |=> board_cs_n[0])
    else $error("disabled board selected");
  power_note_a: assert property ($fell(power_ok_pin) |-> ##3 power_fail && r.stat[3])
    else $error("power loss not reported");
  ref_select_a: assert property ((wr && addr == `DDTC_A_CTRL) |=>
    master_clock_source_ext == $past(wdata[2]))
    else $error("reference select not applied");
  ref_open_a: assert property ((done[0] && !done[9]) |=> r.w[0])
    else $error("reference width not opened");
  ref_close_a: assert property (done[9] |=> !r.w[0])
    else $error("reference width not closed");
  edge_set_a: assert property (done[3] |=> r.e[3])
    else $error("channel edge not raised");
  edge_hold_a: assert property ((r.e[4] && !r.start) |=> r.e[4])
    else $error("channel edge dropped before restart");
  edge_pass_a: assert property (r.gate[13] |=>
    edge_out[8] == ($past(r.pol[13]) ^ $past(r.e[8])))
    else $error("enabled edge not shaped");
  pair_hold_a: assert property ((r.w[1] && !done[2] && !r.start) |=> r.w[1])
    else $error("pair width closed early");
  trig_drop_a: assert property (!r.ctrl[`DDTC_C_ARM] |=> !r.start)
    else $error("disarmed core started a cycle");
  run_drop_a: assert property ((r.st == S_RUN) |=> !r.start)
    else $error("trigger taken while running");
  miss_flag_a: assert property ((trig && r.st == S_RUN) |=> r.stat[`DDTC_S_MISS])
    else $error("missed trigger not flagged");
  synth_start_a: assert property (
    (r.ctrl[1:0] == SRC_SYNTH && r.ctrl[3] && idle_w && synth) |=> r.start)
    else $error("synthesizer tick did not start cycle");
  done_flag_a: assert property ((r.st == S_RUN && busy == '0) |=>
    r.stat[`DDTC_S_DONE] && r.st == S_IDLE)
    else $error("end of cycle not flagged");
  fine_pass_a: assert property (
    (wr && addr == 8'hC0 && wdata[11:0] <= `DDTC_FINE_MAX) |=> r.fine[0] == $past(wdata[11:0]))
    else $error("fine setting not stored");
  pwr_sticky_a: assert property (
    (r.stat[`DDTC_S_PWR] && !(rd && addr == `DDTC_A_STAT)) |=> r.stat[`DDTC_S_PWR])
    else $error("power flag lost without a read");
  cs_quiet_a: assert property (
    (r.ctrl[`DDTC_C_QUIET] && r.st == S_RUN) |=> board_cs_n == 2'b11)
    else $error("board selected during quiet cycle");

  cycle_done_c: cover property (r.st == S_RUN ##1 r.st == S_IDLE);
  trig_miss_c:  cover property (r.stat[`DDTC_S_MISS]);
  power_loss_c: cover property ($fell(r.pwr_s[1]));
  pair_width_c: cover property (r.w[1] ##1 !r.w[1]);
  spi_quiet_c:  cover property (r.ctrl[`DDTC_C_QUIET] && r.st == S_RUN);
endmodule // ddtc_core

//--- verification/ddtc_board_model.sv
// far-side spi boards answering on their data lines
`timescale 1ns/1ps
module ddtc_board_model #(
  parameter logic [1:0] ANS = 2'b01  // level each board answers with
) (
  input  wire logic [1:0] cs_n,      // per-board select, low active
  output logic      [1:0] miso       // per-board data back
);
  // ==========================================================
  // answer path
  // a released line shows the inverse, so a stale level never passes
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      miso[b] = cs_n[b] ? ~ANS[b] : ANS[b];
    end
  end
endmodule // ddtc_board_model

//--- verification/tb_digital_delay_timing_core.sv
// self-checking bench for the delay timing core
`timescale 1ns/1ps
`include "ddtc_regs.svh"
module tb_digital_delay_timing_core;
  logic         clk, reset, wr, rd, irq, power_fail, clk_ext;
  logic         ext_trig, line_trig, power_ok;
  logic         mcu_sck, mcu_mosi, mcu_cs_n, mcu_miso, board_sck, board_mosi;
  logic [1:0]   board_cs_n, board_miso;
  logic [7:0]   addr;
  logic [31:0]  wdata, rdata, rv;
  logic [119:0] fine;
  logic [4:0]   wid_o;
  logic [8:0]   edge_out;
  logic [14:0]  obs;
  int           n_errors, cmp_count, n0, n1;

  assign obs = {power_fail, edge_out, wid_o};

  ddtc_core uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .ext_trig_pin(ext_trig), .line_trig_pin(line_trig),
    .power_ok_pin(power_ok), .power_fail(power_fail), .master_clock_source_ext(clk_ext),
    .mcu_sck(mcu_sck), .mcu_mosi(mcu_mosi), .mcu_cs_n(mcu_cs_n), .mcu_miso(mcu_miso),
    .board_sck(board_sck), .board_mosi(board_mosi), .board_cs_n(board_cs_n),
    .board_miso(board_miso), .fine_delay_vernier(fine), .reference_output(wid_o[0]),
    .pair_one_width_output(wid_o[1]), .pair_two_width_output(wid_o[2]),
    .pair_three_width_output(wid_o[3]), .pair_four_width_output(wid_o[4]),
    .edge_out(edge_out));

  ddtc_board_model #(.ANS(2'b01)) boards (.cs_n(board_cs_n), .miso(board_miso));

  // ==========================================================
  // helpers
  task automatic summarize;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // counts edges until obs[i] shows v
  task automatic wait_obs(input int i, input logic v, output int n);
    n = 0;
    while (obs[i] !== v) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) begin
        n_errors++;
        summarize();
      end
    end
  endtask

  task automatic poll_done(output logic [31:0] acc);
    logic [31:0] d;
    acc = '0;
    for (int k = 0; k < 200 && acc[1] !== 1'b1; k++) begin
      rd_reg(`DDTC_A_STAT, d);
      acc = acc | d;
    end
    if (acc[1] !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask

  task automatic pulse(input logic on_line);
    @(posedge clk);
    if (on_line) line_trig <= 1'b1;
    else ext_trig <= 1'b1;
    repeat (4) @(posedge clk);
    line_trig <= 1'b0;
    ext_trig  <= 1'b0;
  endtask

  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    {reset, wr, rd, ext_trig, line_trig, mcu_sck, mcu_mosi} = '0;
    {power_ok, mcu_cs_n} = 2'b11;
    addr = '0;
    wdata = '0;
    n_errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd_reg(`DDTC_A_RATE, rv);
    check(rv, `DDTC_RATE_RST);
    rd_reg(8'hE8, rv);
    check(rv, 32'h0000_0000);
    check({irq, board_cs_n}, 32'h0000_0003);
    wr_reg(`DDTC_A_CTRL, 32'h0000_0004);
    settle(2);
    check(clk_ext, 1'b1);
    wr_reg(8'hCC, 32'h0000_0FFF);
    wr_reg(8'hC0, 32'h0000_0005);
    wr_reg(8'h94, 32'hFFFF_FFFF);
    rd_reg(8'h94, rv);
    check(rv, 32'h0000_007F);
    settle(2);
    check(fine[47:36], `DDTC_FINE_MAX);
    check(fine[11:0], 12'h005);
    wr_reg(8'h94, 32'h0000_0000);
    wr_reg(8'h44, 32'h0000_0003);
    wr_reg(8'h48, 32'h0000_000A);
    wr_reg(8'h64, 32'h0000_0014);
    wr_reg(`DDTC_A_GATE, 32'h0000_3FFF);
    rd_reg(`DDTC_A_STAT, rv);
    wr_reg(`DDTC_A_CTRL, 32'h0000_0008);
    fork
      begin
        wait_obs(0, 1'b1, n0);
        wait_obs(0, 1'b0, n0);
        check(n0, 20);
      end
      begin
        wait_obs(1, 1'b1, n1);
        wait_obs(1, 1'b0, n1);
        check(n1, 7);
      end
      begin
        pulse(1'b0);
        repeat (8) @(posedge clk);
        pulse(1'b0);
      end
    join
    settle(4);
    rd_reg(`DDTC_A_STAT, rv);
    check(rv[2:0], 3'h7);
    check(edge_out, 9'h1FF);
    wr_reg(`DDTC_A_POL, 32'h0000_3FFF);
    wr_reg(`DDTC_A_GATE, 32'h0000_0000);
    settle(3);
    check({edge_out, wid_o}, 32'h0000_3FFF);
    wr_reg(`DDTC_A_POL, 32'h0000_0020);
    wr_reg(`DDTC_A_GATE, 32'h0000_3FFF);
    settle(3);
    check({edge_out, wid_o}, 32'h0000_3FC0);
    wr_reg(`DDTC_A_RATE, 32'h0000_0010);
    for (int s = 1; s < 3; s++) begin
      rd_reg(`DDTC_A_STAT, rv);
      wr_reg(`DDTC_A_CTRL, 32'h8 | s);
      if (s == 1) pulse(1'b1);
      poll_done(rv);
      check(rv[1:0], 2'h3);
    end
    wr_reg(`DDTC_A_CTRL, 32'h0000_0000);
    settle(40);
    rd_reg(`DDTC_A_STAT, rv);
    pulse(1'b0);
    settle(8);
    rd_reg(`DDTC_A_STAT, rv);
    check(rv, 32'h0000_0000);
    wr_reg(`DDTC_A_MASK, 32'h0000_0000);
    @(posedge clk);
    power_ok <= 1'b0;
    #1;
    wait_obs(14, 1'b1, n0);
    check(n0, 3);
    check(irq, 1'b0);
    wr_reg(`DDTC_A_MASK, 32'h0000_0008);
    settle(1);
    check(irq, 1'b1);
    @(posedge clk);
    power_ok <= 1'b1;
    rd_reg(`DDTC_A_STAT, rv);
    check(rv[3], 1'b1);
    settle(2);
    check(irq, 1'b0);
    wr_reg(`DDTC_A_SPIEN, 32'h0000_0001);
    mcu_cs_n <= 1'b0;
    mcu_sck  <= 1'b1;
    mcu_mosi <= 1'b1;
    settle(6);
    check({board_sck, board_mosi, board_cs_n, mcu_miso}, 32'h0000_001D);
    wr_reg(`DDTC_A_SPIEN, 32'h0000_0002);
    settle(6);
    check({board_cs_n, mcu_miso}, 32'h0000_0002);
    wr_reg(`DDTC_A_CTRL, 32'h0000_0018);
    pulse(1'b0);
    settle(2);
    check(board_cs_n, 2'b11);
    @(posedge clk);
    mcu_cs_n <= 1'b1;
    settle(6);
    check(board_cs_n, 2'b11);
    summarize();
  end
endmodule // tb_digital_delay_timing_core
